// ==== hdl/swdt_top.sv ====
// Purpose: system watchdog timer with AXI4-Lite registers
// Assumes: single 25 MHz clock, synchronous active-low reset
// Notes: dedicated reset pin is active low and idles high; system reset polarity follows bit 2
//
// Contract
// - on expiry drive timeout output as high level, low level or pulse
// - time unit bit 3 selects one-second or sixty-second units
// - pulse width field selects 1 ms, 25 ms, 125 ms or 5 s
// - timeout flag bit 6 sets on timeout, write one clears it
// - count only while count enable bit 5 is one
// - output mode bit 4 selects level when zero, pulse when one
// - polarity bit 2 selects active high when one, low when zero
// - eight-bit writable timeout value sets period in time units
// - early event status sets one unit before or at timeout
// - early events only raised when event enable bit 6 is one
// - dedicated reset pin shows timeout only when gate bit 0 is one
`timescale 1ns/1ns
module swdt_top #(
  parameter int CYC_PER_SEC = swdt_pkg::CYC_PER_SEC,
  parameter int PW0_CYC = swdt_pkg::PW0_CYC,
  parameter int PW1_CYC = swdt_pkg::PW1_CYC,
  parameter int PW2_CYC = swdt_pkg::PW2_CYC,
  parameter int PW3_CYC = swdt_pkg::PW3_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic system_reset_out_n,
  output logic dedicated_timeout_reset_n,
  output logic irq
);
  typedef enum logic [1:0] {
    SWDT_IDLE = 2'b00,
    SWDT_COUNT = 2'b01,
    SWDT_PULSE = 2'b10,
    SWDT_HOLD = 2'b11
  } swdt_state_e;

  // ==========================================================
  // register state
  // ==========================================================
  swdt_pkg::swdt_cfg_s cfg_reg, cfg_next;
  logic [7:0] period_reg, period_next;
  logic timeout_flag_reg, timeout_flag_next;
  logic early_status_reg, early_status_next;
  logic [1:0] irq_stat_reg, irq_stat_next;
  logic [1:0] irq_mask_reg, irq_mask_next;
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [7:0] waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  // watchdog engine
  swdt_state_e state_reg, state_next;
  logic [7:0] count_reg, count_next;
  logic [31:0] pw_reg, pw_next;
  logic out_active_reg, out_active_next;
  logic irq_reg, irq_next;
  logic rst_out_n_reg, rst_out_n_next;
  logic pin_n_reg, pin_n_next;

  logic do_write, reload, unit_tick, expire, early_hit;
  logic [7:0] wbyte;

  function automatic logic [31:0] pulse_cycles(input logic [1:0] sel);
    case (sel)
      2'h0: pulse_cycles = 32'(PW0_CYC);
      2'h1: pulse_cycles = 32'(PW1_CYC);
      2'h2: pulse_cycles = 32'(PW2_CYC);
      default: pulse_cycles = 32'(PW3_CYC);
    endcase
  endfunction

  function automatic logic [7:0] read_reg(input logic [7:0] addr,
      input logic [7:0] ctl, input logic [7:0] per,
      input logic [7:0] evt, input logic [7:0] ist,
      input logic [7:0] imk, output logic hit);
    hit = 1'b1;
    case (addr)
      swdt_pkg::ADDR_CONTROL: read_reg = ctl;
      swdt_pkg::ADDR_PERIOD: read_reg = per;
      swdt_pkg::ADDR_EVENT_CTL: read_reg = evt;
      swdt_pkg::ADDR_IRQ_STATUS: read_reg = ist;
      swdt_pkg::ADDR_IRQ_MASK: read_reg = imk;
      default: begin
        read_reg = 8'h00;
        hit = 1'b0;
      end
    endcase
  endfunction

  swdt_tick #(
    .CYC_PER_SEC(CYC_PER_SEC)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(state_reg == SWDT_COUNT),
    .restart(reload),
    .unit_long(cfg_reg.time_unit_select),
    .unit_tick(unit_tick)
  );

  // ==========================================================
  // AXI4-Lite slave
  // ==========================================================
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wbyte = wstrb_reg[0] ? wdata_reg[7:0] : 8'h00;

  always_comb begin
    logic hit;
    logic [7:0] rbyte;
    hit = 1'b0;
    rbyte = 8'h00;
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_next = 1'b1;
      waddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_reg) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      rbyte = read_reg(waddr_reg, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, hit);
      bresp_next = hit ? swdt_pkg::RESP_OKAY : swdt_pkg::RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rbyte = read_reg(s_axi_araddr,
        {1'b0, timeout_flag_reg, cfg_reg.count_enable,
         cfg_reg.output_mode_select, cfg_reg.time_unit_select,
         cfg_reg.output_polarity_select, cfg_reg.pulse_width_select},
        period_reg,
        {early_status_reg, cfg_reg.early_event_enable, 5'h00,
         cfg_reg.reset_pin_gate},
        {6'h00, irq_stat_reg}, {6'h00, irq_mask_reg}, hit);
      rvalid_next = 1'b1;
      rdata_next = {24'h000000, rbyte};
      rresp_next = hit ? swdt_pkg::RESP_OKAY : swdt_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // ==========================================================
  // register writes and status flags
  // ==========================================================
  always_comb begin
    cfg_next = cfg_reg;
    period_next = period_reg;
    irq_mask_next = irq_mask_reg;
    timeout_flag_next = timeout_flag_reg;
    irq_stat_next = irq_stat_reg;
    early_status_next = early_status_reg;
    reload = 1'b0;
    if (do_write && wstrb_reg[0]) begin
      case (waddr_reg)
        swdt_pkg::ADDR_CONTROL: begin
          if (wbyte[swdt_pkg::BIT_TIMEOUT_FLAG]) begin
            timeout_flag_next = 1'b0;
          end
          cfg_next.count_enable = wbyte[swdt_pkg::BIT_COUNT_ENABLE];
          cfg_next.output_mode_select = wbyte[swdt_pkg::BIT_OUTPUT_MODE];
          cfg_next.time_unit_select = wbyte[swdt_pkg::BIT_TIME_UNIT];
          cfg_next.output_polarity_select = wbyte[swdt_pkg::BIT_POLARITY];
          cfg_next.pulse_width_select =
            wbyte[swdt_pkg::BIT_PW_HI:swdt_pkg::BIT_PW_LO];
          if (wbyte[swdt_pkg::BIT_COUNT_ENABLE] && !cfg_reg.count_enable) begin
            reload = 1'b1;
          end
        end
        swdt_pkg::ADDR_PERIOD: begin
          period_next = wbyte;
          reload = cfg_reg.count_enable;
        end
        swdt_pkg::ADDR_EVENT_CTL: begin
          cfg_next.early_event_enable = wbyte[swdt_pkg::BIT_EARLY_ENABLE];
          cfg_next.reset_pin_gate = wbyte[swdt_pkg::BIT_PIN_GATE];
        end
        swdt_pkg::ADDR_IRQ_STATUS: irq_stat_next = irq_stat_reg & ~wbyte[1:0];
        swdt_pkg::ADDR_IRQ_MASK: irq_mask_next = wbyte[1:0];
        default: ;
      endcase
    end
    // early status follows enable; disabling withdraws the event
    if (!cfg_next.early_event_enable) begin
      early_status_next = 1'b0;
    end else if (early_hit) begin
      early_status_next = 1'b1;
    end
    if (!cfg_next.count_enable) begin
      early_status_next = 1'b0;
    end
    // hardware set wins over a simultaneous clear
    if (expire) begin
      timeout_flag_next = 1'b1;
      irq_stat_next[0] = 1'b1;
    end
    if (early_hit && cfg_reg.early_event_enable) begin
      irq_stat_next[1] = 1'b1;
    end
  end

  // ==========================================================
  // watchdog engine
  // ==========================================================
  assign expire = (state_reg == SWDT_COUNT) && !reload &&
    cfg_reg.count_enable && (count_reg == 8'h00 ||
    (unit_tick && count_reg == 8'h01));
  assign early_hit = (state_reg == SWDT_COUNT) && cfg_reg.count_enable &&
    (count_reg <= 8'h01);

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    pw_next = pw_reg;
    out_active_next = out_active_reg;
    if (!cfg_next.count_enable) begin
      state_next = SWDT_IDLE;
      out_active_next = 1'b0;
    end else begin
      case (state_reg)
        SWDT_IDLE: begin
          state_next = SWDT_COUNT;
          count_next = period_next;
        end
        SWDT_COUNT: begin
          if (reload) begin
            count_next = period_next;
          end else if (expire) begin
            out_active_next = 1'b1;
            count_next = 8'h00;
            if (cfg_reg.output_mode_select) begin
              state_next = SWDT_PULSE;
              pw_next = pulse_cycles(cfg_reg.pulse_width_select) - 32'h1;
            end else begin
              state_next = SWDT_HOLD;
            end
          end else if (unit_tick) begin
            count_next = count_reg - 8'h1;
          end
        end
        SWDT_PULSE: begin
          if (pw_reg == 32'h0) begin
            out_active_next = 1'b0;
            state_next = SWDT_HOLD;
          end else begin
            pw_next = pw_reg - 32'h1;
          end
        end
        SWDT_HOLD: begin
          if (!timeout_flag_next) begin
            out_active_next = 1'b0;
            state_next = SWDT_COUNT;
            count_next = period_next;
          end
        end
        default: state_next = SWDT_IDLE;
      endcase
    end
    // active output level per polarity, inactive is the opposite
    rst_out_n_next = out_active_next ^ ~cfg_next.output_polarity_select;
    pin_n_next = !(out_active_next && cfg_next.reset_pin_gate);
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= '0;
      period_reg <= swdt_pkg::PERIOD_RST;
      timeout_flag_reg <= 1'b0;
      early_status_reg <= 1'b0;
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
      state_reg <= SWDT_IDLE;
      count_reg <= 8'h00;
      pw_reg <= 32'h00000000;
      out_active_reg <= 1'b0;
      irq_reg <= 1'b0;
      rst_out_n_reg <= 1'b1;
      pin_n_reg <= 1'b1;
    end else begin
      cfg_reg <= cfg_next;
      period_reg <= period_next;
      timeout_flag_reg <= timeout_flag_next;
      early_status_reg <= early_status_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      state_reg <= state_next;
      count_reg <= count_next;
      pw_reg <= pw_next;
      out_active_reg <= out_active_next;
      irq_reg <= irq_next;
      rst_out_n_reg <= rst_out_n_next;
      pin_n_reg <= pin_n_next;
    end
  end

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign system_reset_out_n = rst_out_n_reg;
  assign dedicated_timeout_reset_n = pin_n_reg;
  assign irq = irq_reg;

  // ==========================================================
  // checks
  // ==========================================================
  a_flag_on_expire: assert property (@(posedge aclk)
    disable iff (!aresetn) expire |=> timeout_flag_reg)
    else $error("flag not set on expiry");
  a_out_on_expire: assert property (@(posedge aclk)
    disable iff (!aresetn) expire |=> out_active_reg)
    else $error("output not active");
  a_no_count_off: assert property (@(posedge aclk)
    disable iff (!aresetn) !cfg_reg.count_enable |=>
    cfg_reg.count_enable || ($stable(count_reg) && !out_active_reg))
    else $error("count while off");
  a_level_hold: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (state_reg == SWDT_HOLD && out_active_reg && timeout_flag_reg &&
     cfg_reg.count_enable && !do_write) |=> out_active_reg)
    else $error("level dropped early");
  a_polarity_out: assert property (@(posedge aclk)
    disable iff (!aresetn) system_reset_out_n == (out_active_reg ?
    cfg_reg.output_polarity_select : !cfg_reg.output_polarity_select))
    else $error("bad polarity");
  a_pin_gated: assert property (@(posedge aclk)
    disable iff (!aresetn) !cfg_reg.reset_pin_gate |=>
    dedicated_timeout_reset_n || cfg_reg.reset_pin_gate)
    else $error("pin not gated");
  a_early_gate: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !cfg_reg.early_event_enable && !cfg_next.early_event_enable
    |=> !early_status_reg) else $error("early event while off");
  a_pulse_mode: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (expire && cfg_reg.output_mode_select && cfg_next.count_enable)
    |=> state_reg == SWDT_PULSE) else $error("pulse mode missed");
  a_early_set: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (early_hit && cfg_reg.early_event_enable && cfg_next.early_event_enable
     && cfg_next.count_enable) |=> early_status_reg)
    else $error("early status missed");
endmodule

// ==== pkg/swdt_pkg.sv ====
// Purpose: shared constants and types for the system watchdog timer
// Assumes: 25 MHz aclk, AXI4-Lite register access
// Notes: register indices are scaled by four to form byte addresses
package swdt_pkg;
  // ==========================================================
  // clock and time
  // ==========================================================
  localparam int CLK_HZ = 25000000;
  localparam int UNIT_SHORT_S = 1;
  localparam int UNIT_LONG_S = 60;
  localparam int CYC_PER_SEC = CLK_HZ * UNIT_SHORT_S;
  localparam int CYC_PER_MIN_SEC = UNIT_LONG_S;
  localparam int PW0_MS = 1;
  localparam int PW1_MS = 25;
  localparam int PW2_MS = 125;
  localparam int PW3_S = 5;
  localparam int PW0_CYC = CLK_HZ / 1000 * PW0_MS;
  localparam int PW1_CYC = CLK_HZ / 1000 * PW1_MS;
  localparam int PW2_CYC = CLK_HZ / 1000 * PW2_MS;
  localparam int PW3_CYC = CLK_HZ * PW3_S;
  // ==========================================================
  // register map
  // ==========================================================
  localparam logic [7:0] IDX_CONTROL = 8'h05;
  localparam logic [7:0] IDX_PERIOD = 8'h06;
  localparam logic [7:0] IDX_EVENT_CTL = 8'h0A;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h11;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_CTL = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h44;
  // control fields
  localparam int BIT_TIMEOUT_FLAG = 6;
  localparam int BIT_COUNT_ENABLE = 5;
  localparam int BIT_OUTPUT_MODE = 4;
  localparam int BIT_TIME_UNIT = 3;
  localparam int BIT_POLARITY = 2;
  localparam int BIT_PW_HI = 1;
  localparam int BIT_PW_LO = 0;
  // event control fields
  localparam int BIT_EARLY_STATUS = 7;
  localparam int BIT_EARLY_ENABLE = 6;
  localparam int BIT_PIN_GATE = 0;
  // interrupt bits: 0 timeout, 1 early event
  localparam int IRQ_W = 2;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'h00;
  localparam logic [7:0] EVENT_CTL_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic count_enable;
    logic output_mode_select;
    logic time_unit_select;
    logic output_polarity_select;
    logic [1:0] pulse_width_select;
    logic early_event_enable;
    logic reset_pin_gate;
  } swdt_cfg_s;
endpackage

// ==== hdl/swdt_tick.sv ====
// Purpose: prescaler giving one pulse per selected time unit
// Assumes: restart clears the phase so the first unit is whole
// Notes: seconds are counted in cycles, minutes in seconds
`timescale 1ns/1ns
module swdt_tick #(
  parameter int CYC_PER_SEC = swdt_pkg::CYC_PER_SEC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic restart,
  input wire logic unit_long,
  output logic unit_tick
);
  logic [31:0] cyc_reg, cyc_next;
  logic [5:0] sec_reg, sec_next;
  logic sec_tick;

  always_comb begin
    cyc_next = cyc_reg;
    sec_next = sec_reg;
    sec_tick = 1'b0;
    unit_tick = 1'b0;
    if (restart || !run) begin
      cyc_next = 32'h0;
      sec_next = 6'h0;
    end else if (cyc_reg == 32'(CYC_PER_SEC - 1)) begin
      cyc_next = 32'h0;
      sec_tick = 1'b1;
    end else begin
      cyc_next = cyc_reg + 32'h1;
    end
    if (sec_tick) begin
      if (!unit_long) begin
        unit_tick = 1'b1;
      end else if (sec_reg == 6'(swdt_pkg::CYC_PER_MIN_SEC - 1)) begin
        sec_next = 6'h0;
        unit_tick = 1'b1;
      end else begin
        sec_next = sec_reg + 6'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_reg <= 32'h0;
      sec_reg <= 6'h0;
    end else begin
      cyc_reg <= cyc_next;
      sec_reg <= sec_next;
    end
  end
endmodule

// ==== verif/swdt_reset_sink.sv ====
// Purpose: stand-in for the board reset circuitry fed by the watchdog
// Assumes: polarity input follows the programmed output polarity
// Notes: records the length of each active phase and the pin activity
`timescale 1ns/1ns
module swdt_reset_sink (
  input wire logic aclk,
  input wire logic system_reset_out_n,
  input wire logic dedicated_timeout_reset_n,
  input wire logic polarity,
  output int last_width,
  output int pin_count
);
  int run = 0;
  initial last_width = 0;
  initial pin_count = 0;
  // ==========================================================
  // active phase measurement
  // ==========================================================
  // the circuit reacts to whichever level the polarity makes active
  always @(posedge aclk) begin
    if (system_reset_out_n === polarity) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_width <= run;
      run <= 0;
    end
    if (dedicated_timeout_reset_n === 1'b0) begin
      pin_count <= pin_count + 1;
    end
  end
endmodule

// ==== verif/testbench.sv ====
// Purpose: self-checking bench for the system watchdog timer
// Assumes: shortened second of 10 cycles and pulse widths 2,3,4,5
// Notes: registers reached through the AXI4-Lite tasks below
`timescale 1ns/1ns
module testbench;
  localparam logic [7:0] A_CTL = swdt_pkg::ADDR_CONTROL;
  localparam logic [7:0] A_PER = swdt_pkg::ADDR_PERIOD;
  localparam logic [7:0] A_EVT = swdt_pkg::ADDR_EVENT_CTL;
  localparam logic [7:0] A_IST = swdt_pkg::ADDR_IRQ_STATUS;
  localparam logic [7:0] A_IMK = swdt_pkg::ADDR_IRQ_MASK;
  localparam logic [1:0] OK = swdt_pkg::RESP_OKAY;
  localparam logic [1:0] SLV = swdt_pkg::RESP_SLVERR;
  localparam int PWC [4] = '{2, 3, 4, 5};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic pol = 1'b0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, out_n, pin_n, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int last_width, pin_count, t0, n, p0;
  int cyc = 0;
  int n_errors = 0;
  int comparisons = 0;
  always #20 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  swdt_top #(.CYC_PER_SEC(10), .PW0_CYC(2), .PW1_CYC(3), .PW2_CYC(4),
    .PW3_CYC(5)) swdt_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .system_reset_out_n(out_n),
    .dedicated_timeout_reset_n(pin_n), .irq(irq));
  swdt_reset_sink swdt_reset_sink_inst (.aclk(aclk),
    .system_reset_out_n(out_n), .dedicated_timeout_reset_n(pin_n),
    .polarity(pol), .last_width(last_width), .pin_count(pin_count));
  // ==========================================================
  // bus and compare tasks
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // handshakes are judged at the falling edge so no edge race arises
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    logic ta, tw, da, dw;
    logic [1:0] r;
    int k;
    da = 0;
    dw = 0;
    k = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw) && k < 100) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      k++;
      da = da || ta;
      dw = dw || tw;
      awvalid <= !da;
      wvalid <= !dw;
    end
    k = 0;
    do begin
      @(negedge aclk);
      ta = bvalid;
      r = bresp;
      @(posedge aclk);
      k++;
    end while (ta !== 1'b1 && k < 100);
    chk(ta, 1'b1);
    chk(r, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    logic t;
    logic [31:0] d;
    logic [1:0] r;
    int k;
    t = 0;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t && k < 100) begin
      @(negedge aclk);
      t = arvalid && arready;
      @(posedge aclk);
      k++;
    end
    arvalid <= 1'b0;
    k = 0;
    do begin
      @(negedge aclk);
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      k++;
    end while (t !== 1'b1 && k < 100);
    chk(t, 1'b1);
    chk(d, exp);
    chk(r, er);
  endtask
  task automatic wait_out(input logic v);
    n = 0;
    while (out_n !== v && n < 2000) begin
      @(negedge aclk);
      n++;
    end
    @(posedge aclk);
  endtask
  task automatic summarize();
    $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // tests
  // ==========================================================
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_CTL, 0, OK);
    rd(A_PER, 0, OK);
    rd(A_EVT, 0, OK);
    rd(8'h3C, 0, SLV);
    wr(8'h3C, 8'h5A, SLV);
    wr(A_PER, 8'h02, OK);
    rd(A_PER, 2, OK);
    // a write with the low byte lane off must leave the period alone
    wstrb <= 4'h0;
    wr(A_PER, 8'h77, OK);
    wstrb <= 4'hF;
    rd(A_PER, 2, OK);
    repeat (40) @(posedge aclk);
    chk(out_n, 1'b1);
    // level mode, low active, pin gated through, early event on
    wr(A_IMK, 8'h01, OK);
    wr(A_EVT, 8'h41, OK);
    wr(A_CTL, 8'h20, OK);
    t0 = cyc;
    repeat (12) @(posedge aclk);
    rd(A_EVT, 8'hC1, OK);
    wait_out(1'b0);
    chk((cyc - t0) >= 16 && (cyc - t0) <= 24, 1'b1);
    chk(pin_n, 1'b0);
    chk(irq, 1'b1);
    rd(A_IST, 8'h03, OK);
    rd(A_IMK, 8'h01, OK);
    rd(A_CTL, 8'h60, OK);
    repeat (30) @(posedge aclk);
    chk(out_n, 1'b0);
    wr(A_CTL, 8'h60, OK);
    repeat (2) @(posedge aclk);
    chk(out_n, 1'b1);
    rd(A_CTL, 8'h20, OK);
    wr(A_IST, 8'h03, OK);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    // sixty-second unit, one unit period, stopped by disabling
    wr(A_PER, 8'h01, OK);
    wr(A_CTL, 8'h08, OK);
    wr(A_CTL, 8'h28, OK);
    t0 = cyc;
    wait_out(1'b0);
    chk((cyc - t0) >= 595 && (cyc - t0) <= 606, 1'b1);
    wr(A_CTL, 8'h48, OK);
    repeat (2) @(posedge aclk);
    chk(out_n, 1'b1);
    // pulse mode, high active, gate and early event off
    p0 = pin_count;
    wr(A_EVT, 8'h00, OK);
    wr(A_PER, 8'h00, OK);
    wr(A_CTL, 8'h04, OK);
    repeat (3) @(posedge aclk);
    chk(out_n, 1'b0);
    pol <= 1'b1;
    for (int pw = 0; pw < 4; pw++) begin
      wr(A_CTL, 8'h34 | pw[7:0], OK);
      repeat (20) @(posedge aclk);
      chk(last_width, PWC[pw]);
      chk(out_n, 1'b0);
      rd(A_CTL, 8'h74 | pw[7:0], OK);
      rd(A_EVT, 8'h00, OK);
      wr(A_CTL, 8'h44 | pw[7:0], OK);
    end
    chk(pin_count, p0);
    summarize();
  end
  initial begin
    #(40 * 20000);
    n_errors++;
    summarize();
  end
endmodule
